// >>> dv/pcie_global_ctrl_and_pm_caps_tb_top.sv
`timescale 1ns/100ps
// ********************
// bench top
// ********************
module pcie_global_ctrl_and_pm_caps_tb_top;
    import pgc_pkg::*;
    logic        pclk = 0, presetn = 0, aux_resetn = 0;
    logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [15:0] paddr = '0, power_state, ps_m, a;
    logic [31:0] pwdata = '0, prdata, g_m, v, x, e, csr_m [8];
    logic [7:0]  port_enable = 0, ack_go = 0, en, off_seen = 0;
    logic        np_issue = 0, np_done = 0, stray_legacy_ack = 0;
    logic        np_pending, np_timeout, extra_read_queue_en;
    logic        early_data_done_enable, legacy_ack_abort, legacy_sleep_done;
    logic [5:0]  inbound_entry_limit;
    logic [47:0] port_entry_alloc;
    logic [2:0]  dma_request_weight, first_io_unit_request_weight;
    logic [2:0]  second_io_unit_request_weight;
    logic        abort_seen = 0, sleep_seen = 0;
    int          n_errors = 0, compares = 0, seed = 32'hc094;
    int          cyc = 0, t_to = 0, n_to = 0, t0;
    pgc_link_if i_pgc_link_if ();
    // short step period keeps the timeout test brief
    pgc_root #(.BASE_CYC(2), .ROLL_BASES(2)) i_pgc_root (.pclk, .presetn,
        .aux_resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .link(i_pgc_link_if), .port_enable, .np_issue,
        .np_done, .np_pending, .np_timeout, .inbound_entry_limit,
        .port_entry_alloc, .dma_request_weight, .first_io_unit_request_weight,
        .second_io_unit_request_weight, .extra_read_queue_en,
        .early_data_done_enable, .power_state, .legacy_ack_abort,
        .legacy_sleep_done);
    pgc_port i_pgc_port (.pclk, .presetn, .link(i_pgc_link_if), .ack_go,
        .stray_legacy_ack, .turn_off_pending(), .sleep_pending());
    pgc_monitor i_pgc_monitor (.pclk, .presetn,
        .turn_off(i_pgc_link_if.turn_off),
        .turn_off_ack(i_pgc_link_if.turn_off_ack),
        .sleep_request_message(i_pgc_link_if.sleep_request_message),
        .sleep_acknowledge_message(i_pgc_link_if.sleep_acknowledge_message));
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (np_timeout === 1'b1) begin
            t_to <= cyc;
            n_to <= n_to + 1;
        end
        if (legacy_ack_abort === 1'b1) abort_seen <= 1'b1;
        if (legacy_sleep_done === 1'b1) sleep_seen <= 1'b1;
        off_seen <= off_seen | i_pgc_link_if.turn_off;
    end
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : chk
    // request holds until pready
    task automatic xfer(input bit wr, input logic [15:0] ad,
                        input logic [31:0] d, output logic [31:0] rd);
        int n;
        n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, ad, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) n_errors++;
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b0;
        @(posedge pclk);
    endtask : xfer
    // reserved codes leave the field default in force
    function automatic logic [2:0] wt(logic [2:0] c, logic [2:0] d, bit t3);
        return (c == 3'h2 || c == 3'h4 || (t3 && c == 3'h3)) ? c : d;
    endfunction : wt
    task automatic chk_outs();
        int r;
        chk(inbound_entry_limit, g_m[16] ? 41 : 48);
        for (int p = 0; p < 8; p++) begin
            r = (p == 2 || p == 3) ? 4 : 3;
            chk(port_entry_alloc[6*p+:6], (p == 1) ? 6'h0
                : {3'(r), 3'(r - g_m[16])});
        end
        chk(dma_request_weight, wt(g_m[15:13], 3'h2, 0));
        chk(first_io_unit_request_weight, wt(g_m[12:10], 3'h3, 1));
        chk(second_io_unit_request_weight, wt(g_m[9:7], 3'h4, 0));
        chk(extra_read_queue_en, !g_m[3]);
        chk(early_data_done_enable, g_m[2]);
    endtask : chk_outs
    initial begin
        #500000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        aux_resetn <= 1'b1;
        @(posedge pclk);
        g_m = 32'hfffc_4e14;
        xfer(0, OFS_GLOBAL, 0, v);
        chk(v, g_m);
        chk_outs();
        repeat (24) begin
            g_m = $random(seed) & 32'hffff_fffc;
            xfer(1, OFS_GLOBAL, g_m, x);
            xfer(0, OFS_GLOBAL, 0, v);
            chk(v, g_m);
            chk_outs();
        end
        $display("global control test done");
        for (int p = 0; p < 8; p++) begin
            a = 16'(p << 12);
            xfer(1, a | OFS_PM_CAP, 32'hffff_ffff, x);
            xfer(0, a | OFS_PM_CAP, 0, v);
            chk(v, 32'hc802_5801);
            v = $random(seed);
            e = {23'h0, v[8], 6'h0, (^v[1:0]) ? 2'h0 : v[1:0]};
            csr_m[p] = e;
            ps_m[2*p+:2] = e[1:0];
            xfer(1, a | OFS_PM_CSR, v, x);
            xfer(0, a | OFS_PM_CSR, 0, v);
            chk(v, e);
        end
        chk(power_state, ps_m);
        xfer(0, 16'h0100, 0, v);
        chk(v, 0);
        chk(er, 1);
        $display("power management test done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int p = 0; p < 8; p++) begin
            xfer(0, 16'(p << 12) | OFS_PM_CSR, 0, v);
            chk(v, csr_m[p] & 32'h100);
        end
        $display("sticky reset test done");
        g_m = 32'hfffc_4e14;
        en = 8'($random(seed)) | 8'h05;
        port_enable <= en;
        // port 2 withheld so the status must wait for it
        ack_go <= en & 8'hfa;
        xfer(1, OFS_GLOBAL, g_m | 32'h2, x);
        repeat (12) @(posedge pclk);
        xfer(0, OFS_GLOBAL, 0, v);
        chk(v, g_m);
        stray_legacy_ack <= 1'b1;
        @(posedge pclk);
        stray_legacy_ack <= 1'b0;
        ack_go <= 8'hff;
        repeat (12) @(posedge pclk);
        xfer(0, OFS_GLOBAL, 0, v);
        chk(v, g_m | 32'h1);
        chk(abort_seen, 1);
        chk(sleep_seen, 1);
        chk(off_seen, en & 8'hfe);
        xfer(1, OFS_GLOBAL, g_m | 32'h1, x);
        xfer(0, OFS_GLOBAL, 0, v);
        chk(v, g_m);
        $display("turn-off test done");
        g_m[31:18] = 14'h3;
        xfer(1, OFS_GLOBAL, g_m, x);
        np_issue <= 1'b1;
        t0 = cyc;
        @(posedge pclk);
        np_issue <= 1'b0;
        for (int n = 0; n < 60 && n_to == 0; n++) @(posedge pclk);
        chk(t_to - t0 >= 8 && t_to - t0 <= 18, 1);
        np_issue <= 1'b1;
        @(posedge pclk);
        np_issue <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(np_pending, 1);
        np_done <= 1'b1;
        @(posedge pclk);
        np_done <= 1'b0;
        repeat (30) @(posedge pclk);
        chk({np_pending, 8'(n_to)}, 9'h1);
        $display("timeout test done");
        report_and_stop();
    end
endmodule : pcie_global_ctrl_and_pm_caps_tb_top

// >>> dv/pgc_monitor.sv
`timescale 1ns/100ps
// ********************
// link checker
// ********************
module pgc_monitor (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic [7:0] turn_off,
    input wire logic [7:0] turn_off_ack,
    input wire logic       sleep_request_message,
    input wire logic       sleep_acknowledge_message
);
    // requests awaiting an answer
    logic [7:0] seen_ff;
    logic       slp_ff;
    wire  [7:0] nxt_seen = (seen_ff | turn_off) & ~turn_off_ack;
    wire        nxt_slp  = (slp_ff | sleep_request_message)
                           & ~sleep_acknowledge_message;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_ff <= 8'h00;
            slp_ff  <= 1'b0;
        end else begin
            seen_ff <= nxt_seen;
            slp_ff  <= nxt_slp;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_no_legacy_off: assert property (
        turn_off[0] == 1'b0) else $error("turn-off on legacy port");
    a_off_one_pulse: assert property (
        |turn_off |=> turn_off == 8'h00) else $error("turn-off too long");
    a_off_when_idle: assert property (
        |turn_off |-> seen_ff[7:1] == 7'h00) else $error("turn-off resent");
    a_ack_needs_off: assert property (
        (turn_off_ack[7:1] & ~seen_ff[7:1]) == 7'h00)
        else $error("ack without turn-off");
    a_slp_one_pulse: assert property (
        sleep_request_message |=> !sleep_request_message)
        else $error("sleep request too long");
    a_slp_no_repeat: assert property (
        sleep_request_message |-> !slp_ff) else $error("sleep request resent");
    a_slp_ack_order: assert property (
        sleep_acknowledge_message |-> slp_ff)
        else $error("sleep ack without request");
    a_slp_ack_pulse: assert property (
        sleep_acknowledge_message |=> !sleep_acknowledge_message)
        else $error("sleep ack too long");
    c_off: cover property (|turn_off);
    c_ack: cover property (|turn_off_ack[7:1]);
    c_slp: cover property (sleep_acknowledge_message);
endmodule : pgc_monitor

// >>> logic/pgc_link_if.sv
`timescale 1ns/100ps
interface pgc_link_if;
    logic [7:0] turn_off;
    logic [7:0] turn_off_ack;
    logic       sleep_request_message;
    logic       sleep_acknowledge_message;

    modport root (
        output turn_off,
        output sleep_request_message,
        input  turn_off_ack,
        input  sleep_acknowledge_message
    );
    modport port (
        input  turn_off,
        input  sleep_request_message,
        output turn_off_ack,
        output sleep_acknowledge_message
    );
endinterface : pgc_link_if

// >>> logic/pgc_pkg.sv
package pgc_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [11:0] OFS_PM_CAP  = 12'h050;
    localparam logic [11:0] OFS_PM_CSR  = 12'h054;
    localparam logic [11:0] OFS_GLOBAL  = 12'h17c;
    localparam int          PORT_LSB    = 12;
    localparam int          PORTS       = 8;
    localparam int          LEGACY_PORT = 0;
    // ****************************************************************
    // global control fields
    // ****************************************************************
    localparam int TMO_LSB  = 18;
    localparam int RSV17    = 17;
    localparam int THR_BIT  = 16;
    localparam int DMA_LSB  = 13;
    localparam int IOU0_LSB = 10;
    localparam int IOU1_LSB = 7;
    localparam int RSV_LSB  = 4;
    localparam int XQ_BIT   = 3;
    localparam int EDD_BIT  = 2;
    localparam int TOFF_BIT = 1;
    localparam int TACK_BIT = 0;
    localparam logic [13:0] TMO_RST  = 14'h3fff;
    localparam logic [2:0]  DMA_RST  = 3'h2;
    localparam logic [2:0]  IOU0_RST = 3'h3;
    localparam logic [2:0]  IOU1_RST = 3'h4;
    localparam logic [2:0]  RSV_RST  = 3'h1;
    localparam logic        EDD_RST  = 1'b1;
    localparam logic [2:0]  W2       = 3'h2;
    localparam logic [2:0]  W3       = 3'h3;
    localparam logic [2:0]  W4       = 3'h4;
    localparam logic [5:0]  ENTRIES_FULL = 6'h30;
    localparam logic [5:0]  ENTRIES_THR  = 6'h29;
    // ****************************************************************
    // power management fields
    // ****************************************************************
    localparam logic [4:0] PME_SUPPORT = 5'h19;
    localparam logic [2:0] PM_VER      = 3'h2;
    localparam logic [7:0] NEXT_PTR    = 8'h58;
    localparam logic [7:0] CAP_ID      = 8'h01;
    localparam logic [31:0] PM_CAP_WORD = {PME_SUPPORT, 2'h0, 3'h0, 3'h0,
                                           PM_VER, NEXT_PTR, CAP_ID};
    localparam int WKS_BIT = 15;
    localparam int WKE_BIT = 8;
    localparam logic [1:0] PS_D0    = 2'h0;
    localparam logic [1:0] PS_D1    = 2'h1;
    localparam logic [1:0] PS_D2    = 2'h2;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 25000;
    localparam int BASE_NS       = 1536;
    localparam int BASE_CYC      = (BASE_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
    localparam int ROLL_BASES    = 6;

    typedef enum logic [1:0] {
        TO_IDLE = 2'b00,
        TO_SEND = 2'b01,
        TO_WAIT = 2'b11
    } pgc_toff_e;

    // reserved codes fall back to the field default
    function automatic logic [2:0] pgc_weight(input logic [2:0] code,
                                              input logic [2:0] dflt,
                                              input logic       three_ok);
        if (code == W2 || code == W4 || (three_ok && code == W3)) begin
            return code;
        end
        return dflt;
    endfunction : pgc_weight

    // {reads, writes} per port; port 1 has no root port
    function automatic logic [5:0] pgc_alloc(input int p, input logic thr);
        logic [2:0] rd;
        logic [2:0] wr;
        rd = (p == 2 || p == 3) ? 3'h4 : 3'h3;
        wr = thr ? rd - 3'h1 : rd;
        if (p == 1) begin
            return 6'h0;
        end
        return {rd, wr};
    endfunction : pgc_alloc
endpackage : pgc_pkg

// >>> logic/pgc_port.sv
`timescale 1ns/100ps
module pgc_port (
    input  wire logic       pclk,
    input  wire logic       presetn,
    pgc_link_if.port        link,
    input  wire logic [7:0] ack_go,
    input  wire logic       stray_legacy_ack,
    output logic [7:0]      turn_off_pending,
    output logic            sleep_pending
);
    import pgc_pkg::*;

    logic [7:0] pend_ff;
    logic [7:0] ack_ff;
    logic       spend_ff;
    logic       sack_ff;
    wire  [7:0] legacy_mask = 8'h1 << LEGACY_PORT;
    // legacy port never answers a turn-off with an ack [RULE14]
    wire  [7:0] fire = pend_ff & ack_go & ~legacy_mask;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff  <= 8'h0;
            ack_ff   <= 8'h0;
            spend_ff <= 1'b0;
            sack_ff  <= 1'b0;
        end else begin
            pend_ff  <= (pend_ff & ~fire) | (link.turn_off & ~legacy_mask);
            ack_ff   <= fire | // [RULE12]
                        (legacy_mask & {8{stray_legacy_ack}});
            spend_ff <= (spend_ff & ~ack_go[LEGACY_PORT]) |
                        link.sleep_request_message;
            sack_ff  <= spend_ff & ack_go[LEGACY_PORT]; // [RULE14]
        end
    end

    assign link.turn_off_ack              = ack_ff;
    assign link.sleep_acknowledge_message = sack_ff;
    assign turn_off_pending               = pend_ff;
    assign sleep_pending                  = spend_ff;
endmodule : pgc_port

// >>> logic/pgc_root.sv
`timescale 1ns/100ps
// Overview of operation
// [RULE1] 14-bit completion timeout, free timer, 3-bit rollover
// [RULE2] one timeout step lasts about 9.2-10.8 us
// [RULE3] software keeps timeout field at most 0x744
// [RULE4] throttle bit caps inbound entries at 41
// [RULE5] throttled allotment: 3R+2W, ports 2,3 4R+3W
// [RULE6] dma weight field sets successive cacheline requests
// [RULE7] first io unit weight field, default three
// [RULE8] second io unit weight field, default four
// [RULE9] bit 3 removes extra read completion queues
// [RULE10] bit 2 enables early data done, reset one
// [RULE11] turn-off bit broadcasts, hardware clears when sent
// [RULE12] ack status set after all enabled ports ack; code waits only for enabled ports other than the legacy port
// [RULE13] ack on legacy hub link port is aborted
// [RULE14] legacy port uses sleep request/acknowledge instead
// [RULE15] wake support field reads 11001
// [RULE16] first and second sleep state support read zero
// [RULE17] capability id 01, version 010, next 58
// [RULE18] wake status sticky, write one clears, never set
// [RULE19] wake enable sticky writable, no effect
// [RULE20] power state: D1 or D2 writes become D0
// [RULE21] D3hot behaves exactly like D0
// [RULE22] data byte and scaling fields read zero
// [RULE23] elapsed steps reaching limit flag completion timeout
module pgc_root #(
    parameter int BASE_CYC   = pgc_pkg::BASE_CYC,
    parameter int ROLL_BASES = pgc_pkg::ROLL_BASES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        aux_resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    pgc_link_if.root         link,
    input  wire logic [7:0]  port_enable,
    input  wire logic        np_issue,
    input  wire logic        np_done,
    output logic             np_pending,
    output logic             np_timeout,
    output logic [5:0]       inbound_entry_limit,
    output logic [47:0]      port_entry_alloc,
    output logic [2:0]       dma_request_weight,
    output logic [2:0]       first_io_unit_request_weight,
    output logic [2:0]       second_io_unit_request_weight,
    output logic             extra_read_queue_en,
    output logic             early_data_done_enable,
    output logic [15:0]      power_state,
    output logic             legacy_ack_abort,
    output logic             legacy_sleep_done
);
    import pgc_pkg::*;

    // ********************
    // register storage
    // ********************
    logic [13:0] tmo_ff;
    logic        rsv17_ff;
    logic        thr_ff;
    logic [2:0]  dma_ff;
    logic [2:0]  iou0_ff;
    logic [2:0]  iou1_ff;
    logic [2:0]  rsv_ff;
    logic        xq_dis_ff;
    logic        edd_ff;
    logic        toff_req_ff;
    logic        tack_ff;
    logic [15:0] ps_ff;
    logic [7:0]  wake_en_ff;
    logic [7:0]  wake_sts_ff;

    // ********************
    // apb decode, one wait state so read data comes from a flop
    // ********************
    logic        resp_ff;
    logic        slverr_ff;
    logic [31:0] rdata_ff;
    wire  [2:0]  psel_port = paddr[PORT_LSB +: 3];
    wire  [11:0] ofs       = paddr[11:0];
    wire         hit_cap   = (ofs == OFS_PM_CAP);
    wire         hit_csr   = (ofs == OFS_PM_CSR);
    wire         hit_glb   = (ofs == OFS_GLOBAL);
    wire         mapped    = hit_cap | hit_csr | hit_glb;
    wire         access    = psel & penable;
    wire         wr_fire   = access & resp_ff & pwrite & mapped;
    wire         wr_glb    = wr_fire & hit_glb;
    wire         wr_csr    = wr_fire & hit_csr;
    wire  [1:0]  wr_ps     = pwdata[1:0];
    wire  [1:0]  ps_new    = (wr_ps == PS_D1 || wr_ps == PS_D2) ?
                             PS_D0 : wr_ps; // [RULE20]
    wire  [7:0]  port_bit  = 8'h1 << psel_port;

    wire [31:0] glb_word = {tmo_ff, rsv17_ff, thr_ff, dma_ff, iou0_ff,
                            iou1_ff, rsv_ff, xq_dis_ff, edd_ff,
                            toff_req_ff, tack_ff};
    // data, scaling and selector read zero [RULE22]
    wire [31:0] csr_word = {16'h0, wake_sts_ff[psel_port], 6'h0,
                            wake_en_ff[psel_port], 6'h0,
                            ps_ff[psel_port*2 +: 2]};
    // capability word is constant [RULE15] [RULE16] [RULE17]
    wire [31:0] rd_word  = hit_glb ? glb_word :
                           hit_csr ? csr_word :
                           hit_cap ? PM_CAP_WORD : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_ff   <= 1'b0;
            slverr_ff <= 1'b0;
            rdata_ff  <= 32'h0;
        end else begin
            resp_ff <= access & ~resp_ff;
            if (access & ~resp_ff) begin
                slverr_ff <= ~mapped;
                rdata_ff  <= pwrite ? 32'h0 : rd_word;
            end
        end
    end

    assign pready  = resp_ff;
    assign pslverr = resp_ff & slverr_ff;
    assign prdata  = rdata_ff;

    // ********************
    // turn-off broadcast and acknowledge collection
    // ********************
    pgc_toff_e  state_ff;
    logic [7:0] targets_ff;
    logic [7:0] seen_ff;
    logic [7:0] toff_out_ff;
    logic       sleep_req_ff;
    logic       abort_ff;
    logic       sleep_done_ff;
    wire  [7:0] legacy_mask = 8'h1 << LEGACY_PORT;
    wire  [7:0] nxt_targets = port_enable & ~legacy_mask; // [RULE14]
    wire  [7:0] ack_in      = link.turn_off_ack & ~legacy_mask; // [RULE13]
    wire  [7:0] nxt_seen    = seen_ff | (ack_in & targets_ff);
    wire        send        = (state_ff == TO_SEND);
    wire        all_acked   = (state_ff == TO_WAIT) &&
                              (nxt_seen == targets_ff); // [RULE12]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff      <= TO_IDLE;
            targets_ff    <= 8'h0;
            seen_ff       <= 8'h0;
            toff_out_ff   <= 8'h0;
            sleep_req_ff  <= 1'b0;
            abort_ff      <= 1'b0;
            sleep_done_ff <= 1'b0;
        end else begin
            toff_out_ff   <= send ? targets_ff : 8'h0; // [RULE11]
            sleep_req_ff  <= send & port_enable[LEGACY_PORT]; // [RULE14]
            abort_ff      <= link.turn_off_ack[LEGACY_PORT]; // [RULE13]
            sleep_done_ff <= link.sleep_acknowledge_message; // [RULE14]
            case (state_ff)
                TO_IDLE: begin
                    if (toff_req_ff) begin
                        state_ff   <= TO_SEND;
                        targets_ff <= nxt_targets;
                    end
                end
                TO_SEND: begin
                    seen_ff  <= 8'h0;
                    state_ff <= (targets_ff == 8'h0) ? TO_IDLE : TO_WAIT;
                end
                TO_WAIT: begin
                    seen_ff <= nxt_seen;
                    if (all_acked) begin
                        state_ff <= TO_IDLE;
                    end
                end
                default: state_ff <= TO_IDLE;
            endcase
        end
    end

    assign link.turn_off              = toff_out_ff;
    assign link.sleep_request_message = sleep_req_ff;

    // ********************
    // ordinary control fields
    // ********************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmo_ff    <= TMO_RST;
            rsv17_ff  <= 1'b0;
            thr_ff    <= 1'b0;
            dma_ff    <= DMA_RST;
            iou0_ff   <= IOU0_RST;
            iou1_ff   <= IOU1_RST;
            rsv_ff    <= RSV_RST;
            xq_dis_ff <= 1'b0;
            edd_ff    <= EDD_RST; // [RULE10]
            tack_ff   <= 1'b0;
            ps_ff     <= 16'h0;
        end else begin
            if (wr_glb) begin
                tmo_ff    <= pwdata[TMO_LSB +: 14];
                rsv17_ff  <= pwdata[RSV17];
                thr_ff    <= pwdata[THR_BIT];
                dma_ff    <= pwdata[DMA_LSB +: 3];
                iou0_ff   <= pwdata[IOU0_LSB +: 3];
                iou1_ff   <= pwdata[IOU1_LSB +: 3];
                rsv_ff    <= pwdata[RSV_LSB +: 3];
                xq_dis_ff <= pwdata[XQ_BIT];
                edd_ff    <= pwdata[EDD_BIT];
            end
            // a late ack wins over the software clear [RULE12]
            tack_ff <= all_acked |
                       (tack_ff & ~(wr_glb & pwdata[TACK_BIT]));
            if (wr_csr) begin
                ps_ff[psel_port*2 +: 2] <= ps_new; // [RULE20] [RULE21]
            end
        end
    end

    // ********************
    // sticky fields, kept across ordinary reset
    // ********************
    always_ff @(posedge pclk or negedge aux_resetn) begin
        if (!aux_resetn) begin
            toff_req_ff <= 1'b0;
            wake_en_ff  <= 8'h0;
            wake_sts_ff <= 8'h0;
        end else begin
            if (wr_glb & pwdata[TOFF_BIT]) begin
                toff_req_ff <= 1'b1;
            end else if (send) begin
                toff_req_ff <= 1'b0; // [RULE11]
            end
            if (wr_csr) begin
                wake_en_ff[psel_port] <= pwdata[WKE_BIT]; // [RULE19]
                wake_sts_ff <= wake_sts_ff &
                               ~(port_bit & {8{pwdata[WKS_BIT]}}); // [RULE18]
            end
        end
    end

    // ********************
    // completion timeout
    // ********************
    logic        incr;
    logic        busy_ff;
    logic [13:0] elapsed_ff;
    logic        tmo_hit_ff;
    wire         expired = busy_ff && (elapsed_ff >= tmo_ff); // [RULE23]

    pgc_tick_div #(
        .BASE_CYC   (BASE_CYC),
        .ROLL_BASES (ROLL_BASES)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .incr    (incr)
    );

    // one request tracked at a time; issues arriving while it is busy are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_ff    <= 1'b0;
            elapsed_ff <= 14'h0;
            tmo_hit_ff <= 1'b0;
        end else begin
            tmo_hit_ff <= expired; // [RULE23]
            if (!busy_ff) begin
                busy_ff    <= np_issue;
                elapsed_ff <= 14'h0;
            end else if (expired || np_done) begin
                busy_ff <= 1'b0;
            end else if (incr) begin
                elapsed_ff <= elapsed_ff + 14'h1; // [RULE1]
            end
        end
    end

    assign np_pending = busy_ff;
    assign np_timeout = tmo_hit_ff;

    // ********************
    // configuration outputs
    // ********************
    logic [47:0] nxt_alloc;
    logic [47:0] alloc_ff;
    logic [8:0]  weights_ff;

    always_comb begin
        nxt_alloc = 48'h0;
        for (int p = 0; p < PORTS; p++) begin
            nxt_alloc[p*6 +: 6] = pgc_alloc(p, thr_ff); // [RULE5]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alloc_ff   <= 48'h0;
            weights_ff <= {DMA_RST, IOU0_RST, IOU1_RST};
        end else begin
            alloc_ff   <= nxt_alloc;
            weights_ff <= {pgc_weight(dma_ff, DMA_RST, 1'b0),   // [RULE6]
                           pgc_weight(iou0_ff, IOU0_RST, 1'b1), // [RULE7]
                           pgc_weight(iou1_ff, IOU1_RST, 1'b0)}; // [RULE8]
        end
    end

    assign inbound_entry_limit = thr_ff ? ENTRIES_THR :
                                 ENTRIES_FULL; // [RULE4]
    assign port_entry_alloc              = alloc_ff;
    assign dma_request_weight            = weights_ff[8:6];
    assign first_io_unit_request_weight  = weights_ff[5:3];
    assign second_io_unit_request_weight = weights_ff[2:0];
    assign extra_read_queue_en           = ~xq_dis_ff; // [RULE9]
    assign early_data_done_enable        = edd_ff; // [RULE10]
    assign power_state                   = ps_ff;
    assign legacy_ack_abort              = abort_ff;
    assign legacy_sleep_done             = sleep_done_ff;
endmodule : pgc_root

// >>> logic/pgc_tick_div.sv
`timescale 1ns/100ps
module pgc_tick_div #(
    parameter int BASE_CYC   = 62,
    parameter int ROLL_BASES = 6
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      incr
);
    import pgc_pkg::*;

    logic [11:0] base_ff;
    logic [2:0]  roll_ff;
    logic        incr_ff;
    wire         base_end = (base_ff == 12'(BASE_CYC - 1));
    wire         roll_end = (roll_ff == 3'(ROLL_BASES - 1));

    // free running: a fresh request sees its first step early [RULE1]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_ff <= 12'h0;
            roll_ff <= 3'h0;
            incr_ff <= 1'b0;
        end else begin
            base_ff <= base_end ? 12'h0 : base_ff + 12'h1;
            if (base_end) begin
                roll_ff <= roll_end ? 3'h0 : roll_ff + 3'h1; // [RULE1]
            end
            incr_ff <= base_end & roll_end; // [RULE2]
        end
    end

    assign incr = incr_ff;
endmodule : pgc_tick_div
